// *** rtl/async_serial_port.sv ***
// Asynchronous 8/9-bit serial port with AHB-Lite register access
`timescale 1ns/100ps
`include "serial_port_regs.svh"

module async_serial_port (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        timer_run,
   input  wire logic        timer_tick,
   input  wire logic        timer_overflow,
   input  wire logic [7:0]  timer_reload,
   input  wire logic        irq_enable,
   output logic             serial_irq,
   input  wire logic        serial_in_pin,
   output logic             serial_out_pin
);
   import serial_port_pkg::*;

   // ----------------------------------------------------------------
   // Bus slave
   // ----------------------------------------------------------------
   serial_port_pkg::bus_phase_s dp_reg;
   serial_port_pkg::bus_phase_s dp_next;
   logic                        wr_ctrl;
   logic                        wr_data;
   logic                        rd_ctrl;
   logic                        rd_data;

   always_comb begin
      dp_next.valid = hsel & htrans[1] & hready & (hsize == 3'h2);
      dp_next.write = hwrite;
      dp_next.addr  = haddr[11:0];
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_reg <= '0;
      end else begin
         dp_reg <= dp_next;
      end
   end

   assign wr_ctrl   = dp_reg.valid & dp_reg.write & (dp_reg.addr == `CTRL_ADDR);
   assign wr_data   = dp_reg.valid & dp_reg.write & (dp_reg.addr == `DATA_ADDR);
   assign rd_ctrl   = dp_reg.valid & ~dp_reg.write & (dp_reg.addr == `CTRL_ADDR);
   assign rd_data   = dp_reg.valid & ~dp_reg.write & (dp_reg.addr == `DATA_ADDR);
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   control_register_s ctrl_reg;
   control_register_s ctrl_next;
   logic [7:0]        rx_data_reg;
   logic [7:0]        rx_data_next;
   logic              tx_done_set;
   logic              rx_accept;
   logic              rx_ninth;
   logic [9:0]        rx_shift_reg;
   logic [9:0]        rx_shift_next;

   always_comb begin
      ctrl_next = ctrl_reg;
      rx_data_next = rx_data_reg;
      if (wr_ctrl) begin
         ctrl_next = control_register_s'(hwdata[7:0]);
      end
      ctrl_next.unused_one = 1'b1;
      if (tx_done_set) begin
         ctrl_next.tx_done_flag = 1'b1;
      end
      if (rx_accept) begin
         ctrl_next.rx_done_flag = 1'b1;
         ctrl_next.ninth_rx_bit = rx_ninth;
         rx_data_next = rx_shift_reg[7:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_reg    <= control_register_s'(`CTRL_RESET);
         rx_data_reg <= `DATA_RESET;
      end else begin
         ctrl_reg    <= ctrl_next;
         rx_data_reg <= rx_data_next;
      end
   end

   always_comb begin
      hrdata = 32'h0;
      if (rd_ctrl) begin
         hrdata = {24'h0, ctrl_reg};
      end else if (rd_data) begin
         hrdata = {24'h0, rx_data_reg};
      end
   end

   assign serial_irq = irq_enable & (ctrl_reg.tx_done_flag | ctrl_reg.rx_done_flag);

   // ----------------------------------------------------------------
   // Transmitter
   // ----------------------------------------------------------------
   tx_state_e  tx_state_reg;
   tx_state_e  tx_state_next;
   logic       tx_half_reg;
   logic       tx_half_next;
   logic [10:0] tx_frame_reg;
   logic [10:0] tx_frame_next;
   logic [3:0] tx_count_reg;
   logic [3:0] tx_count_next;
   logic [3:0] tx_len_reg;
   logic [3:0] tx_len_next;
   logic       tx_out_reg;
   logic       tx_out_next;
   logic       tx_tick;

   assign tx_tick = timer_overflow & tx_half_reg;

   always_comb begin
      tx_state_next = tx_state_reg;
      tx_half_next  = timer_overflow ? ~tx_half_reg : tx_half_reg;
      tx_frame_next = tx_frame_reg;
      tx_count_next = tx_count_reg;
      tx_len_next   = tx_len_reg;
      tx_out_next   = tx_out_reg;
      tx_done_set   = 1'b0;
      case (tx_state_reg)
         TX_IDLE: begin
            tx_out_next = 1'b1;
            if (wr_data) begin
               tx_state_next = TX_WAIT;
               if (ctrl_reg.frame_mode_select) begin
                  tx_frame_next = {1'b1, ctrl_reg.ninth_tx_bit, hwdata[7:0], 1'b0};
                  tx_len_next   = `FRAME_BITS_9;
               end else begin
                  tx_frame_next = {2'b11, hwdata[7:0], 1'b0};
                  tx_len_next   = `FRAME_BITS_8;
               end
            end
         end
         TX_WAIT: begin
            if (tx_tick) begin
               tx_state_next = TX_SHIFT;
               tx_out_next   = tx_frame_reg[0];
               tx_frame_next = {1'b1, tx_frame_reg[10:1]};
               tx_count_next = 4'd1;
            end
         end
         TX_SHIFT: begin
            if (tx_tick) begin
               if (tx_count_reg == tx_len_reg) begin
                  tx_state_next = TX_IDLE;
                  tx_out_next   = 1'b1;
               end else begin
                  tx_out_next   = tx_frame_reg[0];
                  tx_frame_next = {1'b1, tx_frame_reg[10:1]};
                  tx_count_next = tx_count_reg + 4'd1;
                  tx_done_set   = (tx_count_reg == tx_len_reg - 4'd1);
               end
            end
         end
         default: begin
            tx_state_next = TX_IDLE;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_state_reg <= TX_IDLE;
         tx_half_reg  <= 1'b0;
         tx_frame_reg <= 11'h7ff;
         tx_count_reg <= 4'h0;
         tx_len_reg   <= `FRAME_BITS_8;
         tx_out_reg   <= 1'b1;
      end else begin
         tx_state_reg <= tx_state_next;
         tx_half_reg  <= tx_half_next;
         tx_frame_reg <= tx_frame_next;
         tx_count_reg <= tx_count_next;
         tx_len_reg   <= tx_len_next;
         tx_out_reg   <= tx_out_next;
      end
   end

   assign serial_out_pin = tx_out_reg;

   // ----------------------------------------------------------------
   // Receive bit timer and receiver
   // ----------------------------------------------------------------
   rx_state_e  rx_state_reg;
   rx_state_e  rx_state_next;
   logic [7:0] rx_timer_reg;
   logic [7:0] rx_timer_next;
   logic       rx_phase_reg;
   logic       rx_phase_next;
   logic       rx_prev_reg;
   logic [3:0] rx_count_reg;
   logic [3:0] rx_count_next;
   logic       rx_start;
   logic       rx_ovf;
   logic       rx_sample;
   logic       rx_last;
   logic       rx_stop;

   assign rx_start  = (rx_state_reg == RX_IDLE) & ctrl_reg.receiver_enable
                      & rx_prev_reg & ~serial_in_pin;
   assign rx_ovf    = timer_run & timer_tick & (rx_timer_reg == 8'hff);
   assign rx_sample = rx_ovf & ~rx_phase_reg;
   assign rx_last   = rx_count_reg == (ctrl_reg.frame_mode_select ? `RX_SAMPLES_9 - 4'd1
                                                                  : `RX_SAMPLES_8 - 4'd1);
   assign rx_stop   = serial_in_pin;
   assign rx_ninth  = ctrl_reg.frame_mode_select ? rx_shift_reg[8] : rx_stop;

   always_comb begin
      rx_timer_next = rx_timer_reg;
      rx_phase_next = rx_ovf ? ~rx_phase_reg : rx_phase_reg;
      if (rx_start) begin
         rx_timer_next = timer_reload;
         rx_phase_next = 1'b0;
      end else if (timer_run & timer_tick) begin
         rx_timer_next = (rx_timer_reg == 8'hff) ? timer_reload : rx_timer_reg + 8'h01;
      end
   end

   always_comb begin
      rx_state_next = rx_state_reg;
      rx_shift_next = rx_shift_reg;
      rx_count_next = rx_count_reg;
      rx_accept     = 1'b0;
      case (rx_state_reg)
         RX_IDLE: begin
            if (rx_start) begin
               rx_state_next = RX_START;
            end
         end
         RX_START: begin
            if (rx_sample) begin
               rx_state_next = serial_in_pin ? RX_IDLE : RX_BITS;
               rx_count_next = 4'd0;
            end
         end
         RX_BITS: begin
            if (rx_sample) begin
               rx_shift_next[rx_count_reg] = serial_in_pin;
               rx_count_next = rx_count_reg + 4'd1;
               if (rx_last) begin
                  rx_state_next = RX_IDLE;
                  // Stop check in 8-bit mode, address filter in 9-bit mode
                  rx_accept = ~ctrl_reg.rx_done_flag
                              & (~ctrl_reg.multiproc_stop_check_enable | rx_ninth);
               end
            end
         end
         default: begin
            rx_state_next = RX_IDLE;
         end
      endcase
      if (!ctrl_reg.receiver_enable) begin
         rx_state_next = RX_IDLE;
         rx_accept     = 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_state_reg <= RX_IDLE;
         rx_timer_reg <= 8'h00;
         rx_phase_reg <= 1'b0;
         rx_prev_reg  <= 1'b1;
         rx_shift_reg <= 10'h000;
         rx_count_reg <= 4'h0;
      end else begin
         rx_state_reg <= rx_state_next;
         rx_timer_reg <= rx_timer_next;
         rx_phase_reg <= rx_phase_next;
         rx_prev_reg  <= serial_in_pin;
         rx_shift_reg <= rx_shift_next;
         rx_count_reg <= rx_count_next;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_ti_sticky_hold: assert property (ctrl_reg.tx_done_flag && !wr_ctrl |=> ctrl_reg.tx_done_flag)
      else $error("tx_done_flag dropped without software write");
   a_ri_sticky_hold: assert property (ctrl_reg.rx_done_flag && !wr_ctrl |=> ctrl_reg.rx_done_flag)
      else $error("rx_done_flag dropped without software write");
   a_ctrl_bit6_one: assert property (rd_ctrl |-> hrdata[6])
      else $error("control bit 6 read as zero");
   a_ti_at_stop: assert property (tx_done_set |=> ctrl_reg.tx_done_flag && serial_out_pin)
      else $error("tx_done_flag not set at stop bit start");
   a_tx_start_low: assert property (tx_state_reg == TX_WAIT && tx_tick |=> !serial_out_pin)
      else $error("start bit not low");
   a_tx_write_starts: assert property (tx_state_reg == TX_IDLE && wr_data |=> tx_state_reg == TX_WAIT)
      else $error("data write did not start transmission");
   a_rx_overrun_keep: assert property (ctrl_reg.rx_done_flag && !wr_ctrl |=> $stable(rx_data_reg))
      else $error("receive latch overwritten during overrun");
   a_rx_disable_idle: assert property (!ctrl_reg.receiver_enable |=> rx_state_reg == RX_IDLE)
      else $error("receiver active while disabled");
   a_mp_filter: assert property (rx_state_reg == RX_BITS && rx_sample && rx_last
                                 && ctrl_reg.frame_mode_select && ctrl_reg.multiproc_stop_check_enable
                                 && !rx_shift_reg[8] |=> $stable(rx_data_reg))
      else $error("data byte accepted under address filter");
   a_rx_reload_start: assert property (rx_start |=> rx_timer_reg == $past(timer_reload))
      else $error("receive timer not reloaded on start");
   a_irq_follows: assert property ($rose(ctrl_reg.rx_done_flag) && irq_enable |-> serial_irq)
      else $error("interrupt missing on receive done");
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus response not ready or not okay");
   a_rd_data_latch: assert property (rd_data |-> hrdata == {24'h0, rx_data_reg})
      else $error("data read does not show receive latch");

   // ----------------------------------------------------------------
   // Receive checks
   // ----------------------------------------------------------------
   a_rx_accept_flag: assert property (rx_accept |=> ctrl_reg.rx_done_flag)
      else $error("rx_done_flag not set on accepted byte");
   a_rx_accept_latch: assert property (rx_accept |=> rx_data_reg == $past(rx_shift_reg[7:0]))
      else $error("receive latch not loaded on accepted byte");
   a_rx_stop_rb8: assert property (rx_accept && !ctrl_reg.frame_mode_select
                                   |=> ctrl_reg.ninth_rx_bit == $past(serial_in_pin))
      else $error("stop level not stored in 8-bit mode");
   a_rx_ninth_rb8: assert property (rx_accept && ctrl_reg.frame_mode_select
                                    |=> ctrl_reg.ninth_rx_bit == $past(rx_shift_reg[8]))
      else $error("ninth bit not stored in 9-bit mode");
   a_rx_full_reject: assert property (ctrl_reg.rx_done_flag |-> !rx_accept)
      else $error("byte accepted while receive flag set");
   a_rx_stop_check: assert property (rx_state_reg == RX_BITS && rx_sample && rx_last
                                     && !ctrl_reg.frame_mode_select && ctrl_reg.multiproc_stop_check_enable
                                     && !serial_in_pin |-> !rx_accept)
      else $error("byte accepted with low stop under stop check");
   a_rx_false_start: assert property (rx_state_reg == RX_START && rx_sample && serial_in_pin
                                      |=> rx_state_reg == RX_IDLE)
      else $error("false start not rejected");
   a_rx_start_edge: assert property (rx_state_reg == RX_IDLE && ctrl_reg.receiver_enable
                                     && rx_prev_reg && !serial_in_pin |=> rx_state_reg == RX_START)
      else $error("falling edge did not start reception");

   // ----------------------------------------------------------------
   // Transmit checks and cover points
   // ----------------------------------------------------------------
   a_tx_load_data: assert property (tx_state_reg == TX_IDLE && wr_data
                                    |=> tx_frame_reg[8:1] == $past(hwdata[7:0]))
      else $error("written byte not loaded into shifter");
   a_tx_ninth_bit: assert property (tx_state_reg == TX_IDLE && wr_data && ctrl_reg.frame_mode_select
                                    |=> tx_frame_reg[9] == $past(ctrl_reg.ninth_tx_bit))
      else $error("ninth transmit bit not taken");
   a_tx_mode8_stop: assert property (tx_state_reg == TX_IDLE && wr_data && !ctrl_reg.frame_mode_select
                                     |=> tx_frame_reg[10:9] == 2'b11)
      else $error("8-bit frame does not end in stop");
   a_tx_busy_ignore: assert property (wr_data && tx_state_reg != TX_IDLE && !tx_tick
                                      |=> $stable(tx_frame_reg))
      else $error("data write disturbed a running frame");
   a_tx_idle_high: assert property (tx_state_reg != TX_SHIFT |-> serial_out_pin)
      else $error("transmit line not high outside a frame");
   a_tx_count_range: assert property (tx_state_reg == TX_SHIFT
                                      |-> tx_count_reg <= tx_len_reg && tx_count_reg != 4'h0)
      else $error("transmit bit count out of range");
   a_ti_set_wins: assert property (tx_done_set && wr_ctrl |=> ctrl_reg.tx_done_flag)
      else $error("software write beat hardware set of tx_done_flag");

   c_tx_frame: cover property (tx_done_set && tx_len_reg == `FRAME_BITS_9);
   c_rx_accept: cover property (rx_accept);
   c_rx_overrun: cover property (rx_state_reg == RX_BITS && rx_sample && rx_last && ctrl_reg.rx_done_flag);
   c_false_start: cover property (rx_state_reg == RX_START && rx_sample && serial_in_pin);
   c_mp_address: cover property (rx_accept && ctrl_reg.frame_mode_select && ctrl_reg.multiproc_stop_check_enable);

endmodule

// *** rtl/serial_port_pkg.sv ***
// Types shared by the serial port design
package serial_port_pkg;

   typedef struct packed {
      logic frame_mode_select;
      logic unused_one;
      logic multiproc_stop_check_enable;
      logic receiver_enable;
      logic ninth_tx_bit;
      logic ninth_rx_bit;
      logic tx_done_flag;
      logic rx_done_flag;
   } control_register_s;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [11:0] addr;
   } bus_phase_s;

   typedef enum logic [2:0] {
      TX_IDLE  = 3'b001,
      TX_WAIT  = 3'b010,
      TX_SHIFT = 3'b100
   } tx_state_e;

   typedef enum logic [2:0] {
      RX_IDLE  = 3'b001,
      RX_START = 3'b010,
      RX_BITS  = 3'b100
   } rx_state_e;

endpackage

// *** rtl/serial_port_regs.svh ***
// Register map, field positions, reset values and frame counts of the serial port
//
// Functional notes
// - Control bit 7 selects frame format: 0 gives 8-bit, 1 gives 9-bit.
// - 8-bit frame is ten bit times: start, eight data LSB first, stop.
// - In 8-bit mode an accepted character stores its stop bit in ninth_rx_bit.
// - Writing the data buffer while idle loads the shifter and starts transmission; writes during a frame are ignored.
// - tx_done_flag sets when the last data bit ends, at stop bit start.
// - Reception only starts while receiver_enable is 1; clearing it stops reception.
// - 8-bit byte loads only if rx_done_flag is 0 and, with check enabled, stop is 1.
// - Failed acceptance leaves buffer, ninth_rx_bit and rx_done_flag untouched.
// - On overrun the first byte stays latched; later characters are discarded.
// - Interrupt raised, when enabled, whenever tx_done_flag or rx_done_flag is set.
// - 9-bit frame is eleven bit times: start, eight data, ninth bit, stop.
// - In 9-bit mode ninth_tx_bit is sent as ninth bit; unused in 8-bit mode.
// - In 9-bit mode the ninth bit goes to ninth_rx_bit; stop level ignored.
// - 9-bit mode with multiprocessor bit set accepts only ninth bit 1.
// - Control bit 6 is unused, always reads 1, writes ignored.
// - rx_done_flag sets when the stop bit is sampled, if acceptance holds.
// - Hardware never clears either done flag; only software writing 0 does.
// - Data buffer reads return receive latch; writes go to transmit shifter.
// - Both bit rates equal the shared timer overflow rate divided by two.
// - Receive timer is a private copy, same reload, forced reload on start.
`ifndef SERIAL_PORT_REGS_SVH
`define SERIAL_PORT_REGS_SVH

`define CTRL_INDEX      8'h98
`define DATA_INDEX      8'h99
`define CTRL_ADDR       12'h260
`define DATA_ADDR       12'h264

`define CTRL_RESET      8'h40
`define DATA_RESET      8'h00

`define BIT_MODE        7
`define BIT_UNUSED      6
`define BIT_MCE         5
`define BIT_REN         4
`define BIT_TB8         3
`define BIT_RB8         2
`define BIT_TI          1
`define BIT_RI          0

`define FRAME_BITS_8    4'd10
`define FRAME_BITS_9    4'd11
`define RX_SAMPLES_8    4'd9
`define RX_SAMPLES_9    4'd10

`endif

// *** verif/serial_partner.sv ***
// Far-end asynchronous serial transceiver model
`timescale 1ns/100ps

module serial_partner #(
   parameter int BIT = 32
) (
   input  wire logic hclk,
   input  wire logic nine,
   input  wire logic rx_line,
   output logic      tx_line
);
   logic [9:0] got;
   int         got_count;

   initial begin
      tx_line   = 1'b1;
      got       = '0;
      got_count = 0;
   end

   // ---------------------------------------------
   // Receive: centre samples after a falling edge
   // ---------------------------------------------
   always begin
      @(negedge rx_line);
      repeat (BIT / 2) @(posedge hclk);
      for (int i = 0; i < 10; i++) begin
         if (i < 9 || nine) begin
            repeat (BIT) @(posedge hclk);
            got[i] = rx_line;
         end
      end
      got_count++;
   end

   // ---------------------------------------------
   // Transmit: LSB first, padded with idle bits to twelve bit times
   // ---------------------------------------------
   task automatic send(input logic [7:0] d, input logic b9, input logic stop);
      logic [11:0] frame;
      frame = nine ? {1'b1, stop, b9, d, 1'b0} : {2'b11, stop, d, 1'b0};
      for (int i = 0; i < 12; i++) begin
         @(posedge hclk);
         tx_line <= frame[i];
         repeat (BIT - 1) @(posedge hclk);
      end
   endtask
endmodule

// *** verif/testbench.sv ***
// Self-checking testbench of the serial port
`timescale 1ns/100ps

module testbench;
   import serial_port_pkg::*;
   localparam logic [7:0] RELOAD = 8'hf0;
   localparam int         BIT    = 32;

   logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, nine;
   logic        timer_run, timer_tick, timer_overflow, irq_enable, serial_irq;
   logic        serial_in_pin, serial_out_pin, acc;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [7:0]  timer_reload, tcnt, d, exp_latch;
   logic [31:0] haddr, hwdata, hrdata, seed, rd;
   logic        exp_rb8, exp_ri;
   logic [5:0]  rx_tab [8];
   int          failures, samples_checked, c0;

   assign hready = hreadyout;

   async_serial_port u_async_serial_port (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .timer_run(timer_run), .timer_tick(timer_tick),
      .timer_overflow(timer_overflow), .timer_reload(timer_reload), .irq_enable(irq_enable),
      .serial_irq(serial_irq), .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin)
   );

   serial_partner #(.BIT(BIT)) far_end (
      .hclk(hclk), .nine(nine), .rx_line(serial_out_pin), .tx_line(serial_in_pin)
   );

   initial begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end

   // ---------------------------------------------
   // Shared timer: overflow every 16 ticks
   // ---------------------------------------------
   always @(posedge hclk) begin
      tcnt           <= (tcnt == 8'hff) ? timer_reload : tcnt + 8'h01;
      timer_overflow <= (tcnt == 8'hff);
   end

   // ---------------------------------------------
   // Helpers
   // ---------------------------------------------
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task finish_test;
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task check(input logic [31:0] seen, input logic [31:0] want, input string what);
      samples_checked++;
      if (seen !== want) begin
         failures++;
         $display("BAD %0t %s seen %h want %h", $time, what, seen, want);
      end
   endtask

   task hold_ready;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hready !== 1'b1 && n < 50);
      if (n >= 50) begin
         failures++;
         finish_test;
      end
   endtask

   task xfer(input logic w, input logic [11:0] a, input logic [7:0] wd);
      hsel   <= 1'b1;
      haddr  <= {20'h0, a};
      htrans <= 2'b10;
      hwrite <= w;
      hsize  <= 3'b010;
      hold_ready;
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {24'h0, wd};
      hold_ready;
      rd = hrdata;
   endtask

   task tx_case(input logic m, input logic tb8);
      int n;
      d = 8'(xs());
      xfer(1'b1, 12'h260, {m, 3'b000, tb8, 3'b000});
      c0 = far_end.got_count;
      xfer(1'b1, 12'h264, d);
      n = 0;
      do begin
         xfer(1'b0, 12'h260, 8'h00);
         n++;
      end while (rd[1] !== 1'b1 && n < 400);
      check(n < 400, 1, "tx done flag");
      if (n >= 400) begin
         finish_test;
      end
      check(serial_out_pin, 1, "stop bit at flag");
      check(far_end.got_count, c0, "flag before stop");
      check(serial_irq, irq_enable, "irq");
      repeat (2 * BIT) @(posedge hclk);
      check(far_end.got_count, c0 + 1, "frame count");
      check(far_end.got[7:0], d, "tx data");
      check(far_end.got[8], m ? tb8 : 1'b1, "ninth/stop");
      xfer(1'b0, 12'h260, 8'h00);
      check(rd[1], 1, "flag sticky");
      xfer(1'b1, 12'h260, 8'h00);
      xfer(1'b0, 12'h260, 8'h00);
      check(rd, 32'h40, "flag cleared");
   endtask

   // Table row: mode, mce, ren, ninth, stop, clear
   task rx_case(input logic [5:0] t);
      if (t[0]) begin
         xfer(1'b1, 12'h260, {t[5], 1'b0, t[4], t[3], 4'h0});
         exp_ri  = 1'b0;
         exp_rb8 = 1'b0;
      end
      d    = 8'(xs());
      nine = t[5];
      acc  = t[3] && !exp_ri && (!t[4] || (t[5] ? t[2] : t[1]));
      far_end.send(d, t[2], t[1]);
      if (acc) begin
         exp_latch = d;
         exp_rb8   = t[5] ? t[2] : t[1];
         exp_ri    = 1'b1;
      end
      xfer(1'b0, 12'h260, 8'h00);
      check({rd[2], rd[0]}, {exp_rb8, exp_ri}, "rx flags");
      xfer(1'b0, 12'h264, 8'h00);
      check(rd, exp_latch, "rx latch");
   endtask

   // ---------------------------------------------
   // Main sequence
   // ---------------------------------------------
   initial begin
      seed = 88;
      failures = 0;
      samples_checked = 0;
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = '0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = '0;
      timer_run = 1'b1;
      timer_tick = 1'b1;
      timer_reload = RELOAD;
      tcnt = RELOAD;
      irq_enable = 1'b0;
      nine = 1'b0;
      exp_latch = 8'h00;
      exp_rb8 = 1'b0;
      exp_ri = 1'b0;
      rx_tab = '{6'b001011, 6'b001010, 6'b011001, 6'b001001,
                 6'b111011, 6'b111101, 6'b101001, 6'b000011};
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      check(serial_out_pin, 1, "idle line");
      check({hreadyout, hresp}, 2'b10, "bus response");
      xfer(1'b0, 12'h260, 8'h00);
      check(rd, 32'h40, "control reset");
      xfer(1'b0, 12'h264, 8'h00);
      check(rd, 32'h00, "data reset");
      xfer(1'b0, 12'h100, 8'h00);
      check(rd, 32'h00, "unmapped read");
      xfer(1'b1, 12'h260, 8'h00);
      xfer(1'b0, 12'h260, 8'h00);
      check(rd, 32'h40, "unused bit");
      for (int k = 0; k < 8; k++) begin
         irq_enable <= k[1];
         nine = k[2];
         tx_case(k[2], k[0]);
      end
      for (int k = 0; k < 8; k++)
         rx_case(rx_tab[k]);
      finish_test;
   end
endmodule
